// ==== verilog/sld_pkg.sv ====
package sld_pkg;
  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;  // lcd_display_control
  localparam logic [7:0] ADDR_PTR = 8'h04;  // lcd_ram_pointer
  localparam logic [7:0] ADDR_WIN = 8'h08;  // lcd_ram_window
  localparam logic [7:0] ADDR_MODE = 8'h0c;  // mode_config_register
  localparam logic [7:0] ADDR_ANA = 8'h10;  // analog_config_register
  localparam logic [7:0] ADDR_STAT = 8'h14;  // scan status
  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int CTL_LOW_POS = 1;  // display_ctl_low
  localparam int CTL_HIGH_POS = 2;  // display_ctl_high
  localparam int DUTY_POS = 0;  // duty_select: 1 = quarter duty
  localparam int SAVE_A_POS = 5;  // drive_save_a
  localparam int SAVE_B_POS = 6;  // drive_save_b
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] ANA_RST = 8'h00;
  localparam logic [4:0] PTR_RST = 5'h00;
  localparam int NUM_SEG = 24;
  localparam int NUM_COM = 8;
  // ************************************************************
  // display control codes {high,low}
  // ************************************************************
  localparam logic [1:0] DISP_OFF = 2'h0;
  localparam logic [1:0] DISP_BLANK = 2'h1;
  localparam logic [1:0] DISP_ON = 2'h3;
  // ************************************************************
  // timing: base tick 32.768 kHz from 50 MHz
  // ************************************************************
  localparam int CLK_HZ = 50000000;
  localparam int BASE_HZ = 32768;
  localparam int BASE_DIV = CLK_HZ / BASE_HZ;  // rounded down, 1525
  localparam int TICKS_PER_PHASE = 4;  // base ticks per common phase
  // ************************************************************
  // bias levels (quarter bias: 0..4 of vlcd)
  // ************************************************************
  localparam logic [2:0] LVL_V0 = 3'h0;
  localparam logic [2:0] LVL_V1 = 3'h1;
  localparam logic [2:0] LVL_V3 = 3'h3;
  localparam logic [2:0] LVL_V4 = 3'h4;
  localparam logic [2:0] LVL_MID = 3'h2;  // mid level when display off
  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_HOLD} sld_state_t;
endpackage

// ==== verilog/sld_segment_lcd_driver.sv ====
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - all scan timing from 32.768 kHz tick
// - control field picks off, blank, on
// - duty bit picks eighth or quarter duty
// - quarter bias in both duties
// - ram byte n drives segment n
// - bit k drives common k pixel
// - eight-common mode uses all bits
// - four-common mode: low commons, upper open
// - bit one select, zero non-select
// - five-bit pointer picks ram byte
// - window reads/writes selected ram byte
// - control register clears on reset
// - two drive saving bits in analog register
module sld_segment_lcd_driver #(
  parameter int BASE_DIV = sld_pkg::BASE_DIV,
  parameter int SEG_CNT = sld_pkg::NUM_SEG
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [23:0] segLevel0, // level bit 0 per segment
  output logic [23:0] segLevel1, // level bit 1 per segment
  output logic [23:0] segLevel2, // level bit 2 per segment
  output logic [23:0] comLevel0, // level bits of eight commons (3 each)
  output logic [7:0] comOe, // common drive enables
  output logic driveSaveA,
  output logic driveSaveB
);
  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (BASE_DIV < 2 || BASE_DIV > 65535) begin : g_chk_div
    $error("BASE_DIV out of range");
  end
  if (SEG_CNT != sld_pkg::NUM_SEG) begin : g_chk_seg
    $error("SEG_CNT must be 24");
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] ctrl_ff, nxt_ctrl;  // display control
  logic [4:0] ptr_ff, nxt_ptr;  // ram pointer
  logic [7:0] mode_ff, nxt_mode;  // duty selection
  logic [7:0] ana_ff, nxt_ana;  // drive saving
  logic [7:0] ram_ff [0:31];  // display ram incl. empty bytes
  logic [7:0] ramWrData;  // ram write value
  logic ramWe;  // ram write strobe
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [15:0] div_ff, nxt_div;  // base tick divider
  logic [1:0] sub_ff, nxt_sub;  // base tick count within phase
  logic [2:0] com_ff, nxt_com;  // active common
  logic frame_ff, nxt_frame;  // polarity inversion
  sld_pkg::sld_state_t state_ff, nxt_state;
  logic [23:0] seg0_ff, seg1_ff, seg2_ff, nxt_seg0, nxt_seg1, nxt_seg2;
  logic [23:0] com0_ff, nxt_com0;
  logic [7:0] comOe_ff, nxt_comOe;
  logic [1:0] dispCode;  // {high,low}
  logic quarterDuty;  // four commons
  logic baseTick;  // 32.768 kHz strobe

  // address matcher used by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // one-of-levels waveform for a pixel: select swings full, non-select 3/4 against the selected common
  function automatic logic [2:0] segWave(input logic on, input logic pol);
    if (on) begin
      segWave = pol ? sld_pkg::LVL_V0 : sld_pkg::LVL_V4;
    end else begin
      segWave = pol ? sld_pkg::LVL_V1 : sld_pkg::LVL_V3;
    end
  endfunction

  assign dispCode = {ctrl_ff[sld_pkg::CTL_HIGH_POS], ctrl_ff[sld_pkg::CTL_LOW_POS]};
  assign quarterDuty = mode_ff[sld_pkg::DUTY_POS];
  assign baseTick = (div_ff == 16'(BASE_DIV - 1));

  // ************************************************************
  // apb slave, one wait state: answer in the access cycle's next edge
  // ************************************************************
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ptr = ptr_ff;
    nxt_mode = mode_ff;
    nxt_ana = ana_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    ramWe = 1'b0;
    ramWrData = pwdata[7:0];
    // access phase, answer after one cycle
    if (psel && penable && !pready_ff) begin
      nxt_pready = 1'b1;
      nxt_prdata = 32'h0;
      if (pwrite) begin
        if (hit(paddr, sld_pkg::ADDR_CTRL)) begin
          nxt_ctrl = pwdata[7:0];
        end else if (hit(paddr, sld_pkg::ADDR_PTR)) begin
          nxt_ptr = pwdata[4:0];
        end else if (hit(paddr, sld_pkg::ADDR_WIN)) begin
          ramWe = 1'b1;
        end else if (hit(paddr, sld_pkg::ADDR_MODE)) begin
          // duty change assumed only while off
          nxt_mode = pwdata[7:0];
        end else if (hit(paddr, sld_pkg::ADDR_ANA)) begin
          nxt_ana = pwdata[7:0];
        end else begin
          nxt_pslverr = 1'b1;
        end
      end else begin
        if (hit(paddr, sld_pkg::ADDR_CTRL)) begin
          nxt_prdata = {24'h0, ctrl_ff};
        end else if (hit(paddr, sld_pkg::ADDR_PTR)) begin
          nxt_prdata = {27'h0, ptr_ff};
        end else if (hit(paddr, sld_pkg::ADDR_WIN)) begin
          nxt_prdata = {24'h0, ram_ff[ptr_ff]};
        end else if (hit(paddr, sld_pkg::ADDR_MODE)) begin
          nxt_prdata = {24'h0, mode_ff};
        end else if (hit(paddr, sld_pkg::ADDR_ANA)) begin
          nxt_prdata = {24'h0, ana_ff};
        end else if (hit(paddr, sld_pkg::ADDR_STAT)) begin
          nxt_prdata = {27'h0, frame_ff, com_ff, 1'b0} >> 1;
        end else begin
          nxt_pslverr = 1'b1;
        end
      end
    end
  end

  // register stage of bus and configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff <= sld_pkg::CTRL_RST;
      ptr_ff <= sld_pkg::PTR_RST;
      mode_ff <= sld_pkg::MODE_RST;
      ana_ff <= sld_pkg::ANA_RST;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ptr_ff <= nxt_ptr;
      mode_ff <= nxt_mode;
      ana_ff <= nxt_ana;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ram storage; bytes 18h..1Fh exist but drive no pin
  always_ff @(posedge clk) begin
    if (ramWe) begin
      ram_ff[ptr_ff] <= ramWrData;
    end
  end

  // ************************************************************
  // scan timing
  // ************************************************************
  always_comb begin
    nxt_div = baseTick ? 16'h0 : div_ff + 16'h1;
    nxt_sub = sub_ff;
    nxt_com = com_ff;
    nxt_frame = frame_ff;
    nxt_state = state_ff;
    case (state_ff)
      sld_pkg::ST_IDLE: begin
        // display off: hold scan at start
        nxt_sub = 2'h0;
        nxt_com = 3'h0;
        nxt_frame = 1'b0;
        if (dispCode != sld_pkg::DISP_OFF) begin
          nxt_state = sld_pkg::ST_SCAN;
        end
      end
      sld_pkg::ST_SCAN: begin
        if (dispCode == sld_pkg::DISP_OFF) begin
          nxt_state = sld_pkg::ST_IDLE;
          nxt_sub = 2'h0;
          nxt_com = 3'h0;
          nxt_frame = 1'b0;
        end else if (baseTick) begin
          nxt_sub = sub_ff + 2'h1;
          if (sub_ff == 2'(sld_pkg::TICKS_PER_PHASE - 1)) begin
            if ((quarterDuty && com_ff == 3'h3) || com_ff == 3'h7) begin
              nxt_com = 3'h0;
              nxt_frame = !frame_ff;
            end else begin
              nxt_com = com_ff + 3'h1;
            end
          end
        end
      end
      default: begin
        nxt_state = sld_pkg::ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // waveform generation
  // ************************************************************
  always_comb begin
    logic [2:0] lv;
    logic [7:0] byteVal;
    lv = 3'h0;
    byteVal = 8'h0;
    nxt_seg0 = 24'h0;
    nxt_seg1 = 24'h0;
    nxt_seg2 = 24'h0;
    nxt_com0 = 24'h0;
    nxt_comOe = 8'h0;
    for (int s = 0; s < sld_pkg::NUM_SEG; s++) begin
      byteVal = ram_ff[s];
      if (dispCode == sld_pkg::DISP_ON) begin
        // bit of active common selects waveform
        lv = segWave(byteVal[com_ff], frame_ff);
      end else if (dispCode == sld_pkg::DISP_OFF) begin
        lv = sld_pkg::LVL_MID;
      end else begin
        lv = segWave(1'b0, frame_ff);
      end
      nxt_seg0[s] = lv[0];
      nxt_seg1[s] = lv[1];
      nxt_seg2[s] = lv[2];
    end
    for (int c = 0; c < sld_pkg::NUM_COM; c++) begin
      // quarter bias: selected common full, others 1 or 3
      if (dispCode == sld_pkg::DISP_OFF) begin
        lv = sld_pkg::LVL_MID;
      end else if (c == int'(com_ff)) begin
        lv = frame_ff ? sld_pkg::LVL_V4 : sld_pkg::LVL_V0;
      end else begin
        lv = frame_ff ? sld_pkg::LVL_V3 : sld_pkg::LVL_V1;
      end
      nxt_com0[3*c +: 3] = lv;
      // upper commons open in quarter duty
      nxt_comOe[c] = !(quarterDuty && c >= 4);
    end
  end

  // register stage of scan and outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      div_ff <= 16'h0;
      sub_ff <= 2'h0;
      com_ff <= 3'h0;
      frame_ff <= 1'b0;
      state_ff <= sld_pkg::ST_IDLE;
      seg0_ff <= 24'h0;
      seg1_ff <= 24'h0;
      seg2_ff <= 24'h0;
      com0_ff <= 24'h0;
      comOe_ff <= 8'h0;
    end else begin
      div_ff <= nxt_div;
      sub_ff <= nxt_sub;
      com_ff <= nxt_com;
      frame_ff <= nxt_frame;
      state_ff <= nxt_state;
      seg0_ff <= nxt_seg0;
      seg1_ff <= nxt_seg1;
      seg2_ff <= nxt_seg2;
      com0_ff <= nxt_com0;
      comOe_ff <= nxt_comOe;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign segLevel0 = seg0_ff;
  assign segLevel1 = seg1_ff;
  assign segLevel2 = seg2_ff;
  assign comLevel0 = com0_ff;
  assign comOe = comOe_ff;
  assign driveSaveA = ana_ff[sld_pkg::SAVE_A_POS];
  assign driveSaveB = ana_ff[sld_pkg::SAVE_B_POS];

  // ************************************************************
  // assertions
  // ************************************************************
  a_reset_ctrl_zero: assert property (@(posedge clk) srst |=> ctrl_ff == 8'h0)
    else $error("control not cleared by reset");
  a_quarter_com_limit: assert property (@(posedge clk) disable iff (srst)
    quarterDuty && com_ff <= 3'h3 |=> com_ff <= 3'h3 || $changed(mode_ff))
    else $error("quarter duty scanned past common 3");
  a_upper_open: assert property (@(posedge clk) disable iff (srst)
    !srst && quarterDuty |=> comOe[7:4] == 4'h0)
    else $error("upper commons driven in quarter duty");
  a_full_oe: assert property (@(posedge clk) disable iff (srst)
    !srst && !quarterDuty |=> comOe == 8'hff)
    else $error("commons not all driven in eighth duty");
  a_tick_period: assert property (@(posedge clk) disable iff (srst)
    baseTick |=> !baseTick [*2])
    else $error("base tick too frequent");
  a_blank_nonsel: assert property (@(posedge clk) disable iff (srst)
    dispCode == sld_pkg::DISP_BLANK && $stable(dispCode) |=> segLevel0[0] == 1'b1)
    else $error("blanking drove select level");
  a_off_holds: assert property (@(posedge clk) disable iff (srst)
    state_ff == sld_pkg::ST_IDLE |-> com_ff == 3'h0)
    else $error("scan advanced while off");
  a_ptr_write: assert property (@(posedge clk) disable iff (srst)
    psel && penable && pwrite && !pready && paddr == sld_pkg::ADDR_PTR
    |=> ptr_ff == $past(pwdata[4:0]))
    else $error("pointer not written");
  a_save_bits: assert property (@(posedge clk) disable iff (srst)
    psel && penable && pwrite && !pready && paddr == sld_pkg::ADDR_ANA
    |=> {driveSaveB, driveSaveA} == $past(pwdata[sld_pkg::SAVE_B_POS -: 2]))
    else $error("drive save bits mismatch");
  c_display_on: cover property (@(posedge clk) dispCode == sld_pkg::DISP_ON && baseTick);
  c_blank: cover property (@(posedge clk) dispCode == sld_pkg::DISP_BLANK);
  c_quarter_wrap: cover property (@(posedge clk) quarterDuty && com_ff == 3'h3 ##1 com_ff == 3'h0);
endmodule

// ==== bench/sld_glass_model.sv ====
`timescale 1ns/1ps
// ************************************************************
// glass model: finds the selected common and the dark pixels
// ************************************************************
module sld_glass_model (
  input wire logic [23:0] segLevel0,
  input wire logic [23:0] segLevel1,
  input wire logic [23:0] segLevel2,
  input wire logic [23:0] comLevel0,
  input wire logic [7:0] comOe,
  output logic comValid,
  output logic [2:0] comSel,
  output logic [23:0] litSeg
);
  logic [2:0] lv; // level on one common
  logic [2:0] sv; // level on one segment
  // a pixel darkens only across a full swing of four steps
  // quarter bias swing
  always_comb begin
    comValid = 1'b0;
    comSel = 3'h0;
    litSeg = 24'h0;
    lv = 3'h0;
    sv = 3'h0;
    for (int c = 0; c < 8; c++) begin
      lv = comLevel0[3*c +: 3];
      // only a driven common at an outer level is selected
      if (comOe[c] && (lv == 3'h0 || lv == 3'h4)) begin
        comValid = 1'b1;
        comSel = 3'(c);
        for (int s = 0; s < 24; s++) begin
          sv = {segLevel2[s], segLevel1[s], segLevel0[s]};
          litSeg[s] = ((sv > lv) ? sv - lv : lv - sv) == 3'h4;
        end
      end
    end
  end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  localparam int BDIV = 4; // short base divider
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, driveSaveA, driveSaveB, comValid;
  logic [23:0] segLevel0, segLevel1, segLevel2, comLevel0, litSeg;
  logic [7:0] comOe;
  logic [2:0] comSel;
  logic [33:0] noteQ[$]; // {is read, error, data}
  logic [7:0] ram[32]; // shadow of display ram
  logic [31:0] rnd = 32'h622162ad;
  int num_errors = 0;
  int tests_run = 0;
  // ************************************************************
  // clock, design and glass
  // ************************************************************
  always #10 clk = ~clk;
  sld_segment_lcd_driver #(.BASE_DIV(BDIV)) sld_segment_lcd_driver_inst (.clk, .srst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .segLevel0,
    .segLevel1, .segLevel2, .comLevel0, .comOe, .driveSaveA, .driveSaveB);
  sld_glass_model sld_glass_model_inst (.segLevel0, .segLevel1, .segLevel2, .comLevel0,
    .comOe, .comValid, .comSel, .litSeg);
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [23:0] litOf(input int c);
    logic [23:0] r;
    for (int s = 0; s < 24; s++) r[s] = ram[s][c];
    return r;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [33:0] note);
    noteQ.push_back(note);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {2'b10, e});
  endtask
  task automatic ctl(input logic [1:0] code);
    wr(sld_pkg::ADDR_CTRL, 32'({code, 1'b0}));
  endtask
  // wait for common c to be selected, then check the lit segments
  task automatic scan(input int c, input logic [23:0] e);
    while (!(comValid === 1'b1 && comSel === 3'(c))) begin
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    chk(32'(litSeg), 32'(e));
  endtask
  // ************************************************************
  // watcher: compare each answer with the oldest note
  // ************************************************************
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      logic [33:0] note;
      note = noteQ.pop_front();
      chk(32'(pslverr), 32'(note[32]));
      if (note[33]) chk(prdata, note[31:0]);
    end
  end
  task automatic wrap_up;
    $display("checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(60000 * 20);
    num_errors++;
    wrap_up;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int n;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(sld_pkg::ADDR_CTRL, 32'h0);
    rd(sld_pkg::ADDR_MODE, 32'h0);
    apb(1'b0, 8'h18, 32'h0, {2'b11, 32'h0});
    $display("reset test done");
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      ram[i] = rnd[7:0];
      wr(sld_pkg::ADDR_PTR, 32'(i));
      wr(sld_pkg::ADDR_WIN, 32'(ram[i]));
    end
    for (int i = 0; i < 32; i++) begin
      wr(sld_pkg::ADDR_PTR, 32'(i));
      rd(sld_pkg::ADDR_WIN, 32'(ram[i]));
    end
    wr(sld_pkg::ADDR_PTR, 32'h3f);
    rd(sld_pkg::ADDR_PTR, 32'h1f);
    $display("ram test done");
    ctl(sld_pkg::DISP_ON);
    for (int c = 0; c < 8; c++) scan(c, litOf(c));
    chk(32'(comOe), 32'hff);
    ctl(sld_pkg::DISP_BLANK);
    scan(3, 24'h0);
    scan(6, 24'h0);
    ctl(2'h2);
    scan(1, 24'h0);
    ctl(sld_pkg::DISP_OFF);
    repeat (3) @(posedge clk);
    chk(32'(segLevel1 & ~segLevel0 & ~segLevel2), 32'hffffff);
    chk(32'(comValid), 32'h0);
    rd(sld_pkg::ADDR_STAT, 32'h0);
    $display("control test done");
    // display is off before the duty changes
    // off before duty
    wr(sld_pkg::ADDR_MODE, 32'h1);
    ctl(sld_pkg::DISP_ON);
    for (int c = 0; c < 4; c++) scan(c, litOf(c));
    chk(32'(comOe), 32'h0f);
    n = 0;
    while (comSel !== 3'h1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (comSel === 3'h1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n), 32'(sld_pkg::TICKS_PER_PHASE * BDIV));
    $display("duty test done");
    wr(sld_pkg::ADDR_ANA, 32'h60);
    chk({30'h0, driveSaveB, driveSaveA}, 32'h3);
    wr(sld_pkg::ADDR_ANA, 32'h20);
    chk({30'h0, driveSaveB, driveSaveA}, 32'h1);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(sld_pkg::ADDR_CTRL, 32'h0);
    $display("power and reset test done");
    wrap_up;
  end
endmodule
